// *** rtl/ebp_top.sv ***
// external bus port: master sequencer, slave response and pin drive
`timescale 1ns/1ps
module ebp_top
  import ebp_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // configuration
  input  wire logic [BSEL_W-1:0] bank_size_i,
  input  wire logic [PSEL_W-1:0] page_size_i,
  input  wire logic              bus_master_i,
  input  wire logic              bus_granted_away_i,
  input  wire logic              suspend_tristate_n_i,
  // core request
  input  wire logic              req_i,
  input  wire logic              req_write_i,
  input  wire logic              req_cond_i,
  input  wire ebp_fmt_t          req_fmt_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [39:0]       req_wdata_i,
  output logic                   req_busy_o,
  output logic                   done_o,
  output logic [39:0]            rdata_o,
  // slave side toward internal memory
  output logic                   slv_req_o,
  output logic                   slv_write_o,
  output logic [ADDR_W-1:0]      slv_addr_o,
  output logic [39:0]            slv_wdata_o,
  input  wire logic [3:0]        slv_wait_i,
  // address pins
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   addr_oe_o,
  // data pins
  input  wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_o,
  // selects and strobes
  output logic [NBANK-1:0]       bank_select_n_o,
  output logic                   ctl_oe_o,
  input  wire logic              rd_n_i,
  output logic                   rd_n_o,
  input  wire logic              wr_n_i,
  output logic                   wr_n_o,
  input  wire logic              early_store_select_n_i,
  output logic                   early_store_select_n_o,
  output logic                   page_o,
  output logic                   bus_reference_clock_o,
  // acknowledge
  input  wire logic              ack_i,
  output logic                   ack_o,
  output logic                   ack_oe_o
);
  ebp_state_t state_r;
  logic [ADDR_W-1:0] last_page_r;
  logic       page_valid_r;
  logic       ack_eff;
  logic       float_now;
  logic       susp_r;
  logic       wr_cur_r;
  logic       cond_cur_r;
  ebp_fmt_t   fmt_cur_r;
  logic [39:0] wdata_cur_r;
  logic [DATA_W-1:0] lane_out;
  logic [39:0] lane_in;
  logic [3:0] slv_cnt_r;
  logic       slv_act_r;
  logic       slv_wr_r;
  logic       grant_s;
  logic [NBANK-1:0] bank_dec;
  logic [ADDR_W-1:0] bank_idx;
  logic [ADDR_W-1:0] pg_mask;

  // grant from arbitration arrives asynchronously
  ebp_sync #(.W(1), .INIT(1'b0)) u_grant_sync (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .d_i       (bus_granted_away_i),
    .q_o       (grant_s)
  );

  ebp_lanes u_lanes (
    .fmt_i   (fmt_cur_r),
    .wdata_i (wdata_cur_r),
    .rdata_o (lane_in),
    .bus_i   (data_i),
    .bus_o   (lane_out)
  );

  // the pad keeper holds ack at its last driven level, so the core always sees a
  // defined level; it is used in the cycle it is sampled, since a registered copy
  // would end a waited access one cycle early
  assign ack_eff = ack_i;

  always_comb begin
    bank_idx = req_addr_i >> bank_size_i;
    bank_dec = BANK_IDLE;
    if (bank_idx < NBANK) bank_dec[bank_idx[1:0]] = 1'b0;
    pg_mask = {ADDR_W{1'b1}} << page_size_i;
  end

  assign float_now = grant_s || !susp_r || !bus_master_i;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) susp_r <= 1'b1;
    else susp_r <= suspend_tristate_n_i;
  end

  // master sequencer
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_r <= EBP_ST_IDLE;
      wr_cur_r <= 1'b0;
      cond_cur_r <= 1'b0;
      fmt_cur_r <= EBP_FMT_W32;
      wdata_cur_r <= '0;
      addr_o <= '0;
      bank_select_n_o <= BANK_IDLE;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      early_store_select_n_o <= 1'b1;
      page_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= '0;
      req_busy_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_r)
        EBP_ST_IDLE: begin
          page_o <= 1'b0;
          if (req_i && !float_now) begin
            state_r <= EBP_ST_ADDR;
            req_busy_o <= 1'b1;
            wr_cur_r <= req_write_i;
            cond_cur_r <= req_cond_i;
            fmt_cur_r <= req_fmt_i;
            wdata_cur_r <= req_wdata_i;
            addr_o <= req_addr_i;
            bank_select_n_o <= bank_dec;
            early_store_select_n_o <= !req_write_i;
            page_o <= !bank_dec[0] && (!page_valid_r ||
                      ((req_addr_i & pg_mask) != last_page_r));
          end
        end
        EBP_ST_ADDR: begin
          state_r <= EBP_ST_WAIT;
          page_o <= 1'b0;
          // false conditional keeps selects but never strobes
          rd_n_o <= !(!wr_cur_r && cond_cur_r);
          wr_n_o <= !(wr_cur_r && cond_cur_r);
        end
        EBP_ST_WAIT: begin
          if (ack_eff && susp_r) begin
            state_r <= EBP_ST_DONE;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            rdata_o <= lane_in;
          end
        end
        EBP_ST_DONE: begin
          state_r <= EBP_ST_IDLE;
          bank_select_n_o <= BANK_IDLE;
          early_store_select_n_o <= 1'b1;
          done_o <= 1'b1;
          req_busy_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      last_page_r <= '0;
      page_valid_r <= 1'b0;
    end else if (state_r == EBP_ST_IDLE && req_i && !float_now && !bank_dec[0]) begin
      last_page_r <= req_addr_i & pg_mask;
      page_valid_r <= 1'b1;
    end
  end

  // pin enables
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      addr_oe_o <= 1'b0;
      ctl_oe_o  <= 1'b0;
      data_oe_o <= 1'b0;
      data_o    <= '0;
    end else begin
      // suspend is taken straight from the pin so every enable drops in the next cycle
      addr_oe_o <= !float_now && suspend_tristate_n_i;
      ctl_oe_o  <= bus_master_i && !grant_s && suspend_tristate_n_i;
      data_oe_o <= !float_now && suspend_tristate_n_i && wr_cur_r && state_r != EBP_ST_IDLE;
      data_o    <= lane_out;
    end
  end

  // bus reference clock: halved core clock, master only
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) bus_reference_clock_o <= 1'b0;
    else if (bus_master_i) bus_reference_clock_o <= !bus_reference_clock_o;
    else bus_reference_clock_o <= 1'b0;
  end

  // slave response to a foreign master
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      slv_act_r <= 1'b0;
      slv_wr_r <= 1'b0;
      slv_cnt_r <= '0;
      slv_req_o <= 1'b0;
      slv_write_o <= 1'b0;
      slv_addr_o <= '0;
      slv_wdata_o <= '0;
      ack_o <= 1'b1;
      ack_oe_o <= 1'b0;
    end else begin
      slv_req_o <= 1'b0;
      if (!bus_master_i && !slv_act_r && (!rd_n_i || !wr_n_i)) begin
        slv_act_r <= 1'b1;
        slv_wr_r <= !early_store_select_n_i;
        slv_addr_o <= addr_i;
        slv_cnt_r <= slv_wait_i;
        ack_o <= (slv_wait_i == '0);
        ack_oe_o <= 1'b1;
      end else if (slv_act_r) begin
        if (slv_cnt_r != '0) begin
          slv_cnt_r <= slv_cnt_r - 4'h0_1;
          ack_o <= (slv_cnt_r == 4'h0_1);
        end else begin
          slv_act_r <= 1'b0;
          slv_req_o <= 1'b1;
          slv_write_o <= slv_wr_r;
          slv_wdata_o <= data_i[DATA_W-1:LANE40_LO];
          ack_o <= 1'b1;
          ack_oe_o <= 1'b0;
        end
      end
    end
  end

  property p_strobe_needs_ack;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == EBP_ST_WAIT && !ack_eff) |=> (state_r == EBP_ST_WAIT);
  endproperty
  a_strobe_needs_ack: assert property (p_strobe_needs_ack)
    else $error("access ended while ack low");

  property p_sel_idle;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == EBP_ST_IDLE && !done_o) |-> bank_select_n_o == BANK_IDLE;
  endproperty
  a_sel_idle: assert property (p_sel_idle)
    else $error("bank select active while idle");

  property p_early_with_addr;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == EBP_ST_ADDR) |-> (early_store_select_n_o == !wr_cur_r);
  endproperty
  a_early_with_addr: assert property (p_early_with_addr)
    else $error("early store select not with address");

  property p_page_bank0;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      page_o |-> !bank_select_n_o[0];
  endproperty
  a_page_bank0: assert property (p_page_bank0)
    else $error("page outside bank 0");

  property p_hold_addr;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == EBP_ST_WAIT) |-> $stable(addr_o) && $stable(bank_select_n_o);
  endproperty
  a_hold_addr: assert property (p_hold_addr)
    else $error("address moved during access");

  property p_susp_float;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      !suspend_tristate_n_i |=> !ctl_oe_o && !addr_oe_o && !data_oe_o;
  endproperty
  a_susp_float: assert property (p_susp_float)
    else $error("outputs driven under suspend");

  property p_cond_false_no_strobe;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == EBP_ST_ADDR && !cond_cur_r) |=> rd_n_o && wr_n_o;
  endproperty
  a_cond_false_no_strobe: assert property (p_cond_false_no_strobe)
    else $error("strobe on false conditional");

  property p_strobe_kind;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (state_r == EBP_ST_ADDR && cond_cur_r) |=> (wr_cur_r ? !wr_n_o : !rd_n_o);
  endproperty
  a_strobe_kind: assert property (p_strobe_kind)
    else $error("wrong strobe");

  property p_grant_float;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      grant_s |=> !addr_oe_o && !data_oe_o && !ctl_oe_o;
  endproperty
  a_grant_float: assert property (p_grant_float)
    else $error("outputs driven after bus granted away");

  property p_slv_ack_drive;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (!bus_master_i && !slv_act_r && (!rd_n_i || !wr_n_i)) |=> ack_oe_o;
  endproperty
  a_slv_ack_drive: assert property (p_slv_ack_drive)
    else $error("slave access without ack drive");
endmodule

// *** rtl/ebp_pkg.sv ***
// package of constants for the external bus port
// Functional notes
// - as master, drive the access address on the 32-bit address outputs
// - a foreign master drives the address; the port takes it as input
// - 32-bit float and fixed words use data lanes 47..16
// - 40-bit extended float words use data lanes 47..8
// - 16-bit short words use data lanes 31..16
// - byte-wide prom boot takes each byte from lanes 23..16
// - one of four active-low bank selects marks the addressed bank
// - bank selects are decoded from the address and change with it
// - selects idle without access, but assert for false conditional accesses
// - read strobe low while mastering a read; outside reader drives it itself
// - store strobe low while mastering a write; outside writer drives it itself
// - page output asserts on a dram page crossing, bank 0 only
// - only the current master drives selects, page and reference clock; the reference clock has no enable and is driven low when not master
// - early store select warns of a write; abandoned if no store strobe
// - early store select asserts in the cycle the address first appears
// - as slave, sample early store select to tell read from write
// - acknowledge low inserts wait states; access cannot end meanwhile
// - as slave, drive acknowledge low to stretch the master's access
// - master keeps its acknowledge input at the last driven level
// - asynchronous inputs are synchronised before use; only the grant passes ebp_sync, suspend, strobes and ack are used directly
// - when the bus is granted away, address, data, selects, strobes float
// - suspend-tristate low floats address, data, selects, strobes next cycle
package ebp_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 48;
  localparam int NBANK  = 4;
  localparam int BSEL_W = 5;   // bank size field: log2 of bank size in words
  localparam int PSEL_W = 5;   // page size field: log2 of page size in words
  localparam logic [NBANK-1:0] BANK_IDLE = 4'h0_00F;
  localparam logic [1:0]       BANK_CNT_MAX = 2'h3;
  localparam logic [BSEL_W-1:0] BANK_SIZE_RST = 5'h0_10;
  localparam logic [PSEL_W-1:0] PAGE_SIZE_RST = 5'h0_08;
  // data formats
  typedef enum logic [1:0] {
    EBP_FMT_W32 = 2'h0,
    EBP_FMT_W40 = 2'h1,
    EBP_FMT_W16 = 2'h2,
    EBP_FMT_B8  = 2'h3
  } ebp_fmt_t;
  localparam int LANE32_LO = 16;
  localparam int LANE40_LO = 8;
  localparam int LANE16_LO = 16;
  localparam int LANE16_HI = 31;
  localparam int LANE8_LO  = 16;
  localparam int LANE8_HI  = 23;
  // master sequencer, gray coded along idle-addr-wait-done
  typedef enum logic [1:0] {
    EBP_ST_IDLE = 2'b00,
    EBP_ST_ADDR = 2'b01,
    EBP_ST_WAIT = 2'b11,
    EBP_ST_DONE = 2'b10
  } ebp_state_t;
  localparam logic [3:0] SLV_WAIT_RST = 4'h0_2;
endpackage

// *** rtl/ebp_sync.sv ***
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module ebp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      meta_r <= INIT;
      q_o    <= INIT;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// *** rtl/ebp_lanes.sv ***
// data lane steering for each word format
`timescale 1ns/1ps
module ebp_lanes
  import ebp_pkg::*;
(
  // format
  input  wire ebp_fmt_t            fmt_i,
  // core side word, right aligned
  input  wire logic [39:0]         wdata_i,
  output logic      [39:0]         rdata_o,
  // bus side lanes
  input  wire logic [DATA_W-1:0]   bus_i,
  output logic      [DATA_W-1:0]   bus_o
);
  always_comb begin
    bus_o   = '0;
    rdata_o = '0;
    unique case (fmt_i)
      EBP_FMT_W32: begin
        bus_o[DATA_W-1:LANE32_LO] = wdata_i[31:0];
        rdata_o[31:0] = bus_i[DATA_W-1:LANE32_LO];
      end
      EBP_FMT_W40: begin
        bus_o[DATA_W-1:LANE40_LO] = wdata_i;
        rdata_o = bus_i[DATA_W-1:LANE40_LO];
      end
      EBP_FMT_W16: begin
        bus_o[LANE16_HI:LANE16_LO] = wdata_i[15:0];
        rdata_o[15:0] = bus_i[LANE16_HI:LANE16_LO];
      end
      EBP_FMT_B8: begin
        bus_o[LANE8_HI:LANE8_LO] = wdata_i[7:0];
        rdata_o[7:0] = bus_i[LANE8_HI:LANE8_LO];
      end
    endcase
  end
endmodule

// *** tb/ebp_mem_model.sv ***
// external memory model answering the port while it masters the bus
`timescale 1ns/1ps
module ebp_mem_model
  import ebp_pkg::*;
(
  // clock
  input  wire logic              clk_sys_i,
  // bus seen from the memory
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [NBANK-1:0]  bsel_i,
  input  wire logic              page_i,
  input  wire logic              oe_i,
  input  wire logic              rd_n_i,
  input  wire logic              wr_n_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic [3:0]        wait_i,
  output logic                   ack_o,
  output logic [DATA_W-1:0]      data_o,
  // what the bus showed during the strobe
  output logic [ADDR_W-1:0]      cap_addr_o,
  output logic [NBANK-1:0]       cap_bsel_o,
  output logic                   cap_page_o,
  output logic                   cap_oe_o,
  output logic [DATA_W-1:0]      cap_wdata_o
);
  logic [3:0]        cnt_r;
  logic              act;
  logic [DATA_W-1:0] pat;
  logic              act_d;
  logic              pg_d;
  assign act = !rd_n_i || !wr_n_i;
  assign pat = {~addr_i[15:0], addr_i};
  // ack low for wait_i cycles of each strobe, pulled up otherwise
  assign ack_o = !(act && cnt_r < wait_i);
  // data valid only once ack rises, so a port that ignores waits reads garbage
  assign data_o = (!rd_n_i && ack_o) ? pat : ~pat;
  always_ff @(posedge clk_sys_i) begin
    cnt_r <= act ? cnt_r + 4'h1 : 4'h0;
    act_d <= act;
    pg_d  <= page_i;
    // page pulses with the address, a cycle before the strobe; keep the value
    // that stood just before the strobe fell
    if (act && !act_d) begin
      cap_page_o <= pg_d;
    end
    if (act) begin
      cap_addr_o <= addr_i;
      cap_bsel_o <= bsel_i;
      cap_oe_o   <= oe_i;
      if (!wr_n_i) begin
        cap_wdata_o <= data_i;
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the external bus port
`timescale 1ns/1ps
module tb_top
  import ebp_pkg::*;
;
  typedef struct {
    logic slv, wr, pg, c;
    ebp_fmt_t f;
    logic [31:0] a;
    logic [39:0] d;
    logic [3:0] w, bs;
  } ebp_exp_t;
  logic clk, rstn, mst, away, susp_n, req, req_wr, req_cond, busy, done;
  logic s_rd_n, s_wr_n, s_esel_n, slv_req, slv_wr, aoe, doe, coe, rd_n, wr_n, esel_n;
  logic page, ack_o, ack_oe, ack_m, c_page, c_oe, pg_new, rclk, rclk_d;
  ebp_fmt_t fmt;
  logic [4:0] bsz, psz;
  logic [31:0] raddr, s_addr, slv_addr, addr_o, c_addr, last_pg;
  logic [39:0] wdat, rdata, slv_wdat;
  logic [3:0] s_wait, m_wait, bsel, c_bsel;
  logic [47:0] data_o, data_m, c_wdat, s_data;
  ebp_exp_t exq[$];
  ebp_exp_t e;
  int failures = 0;
  int cmp_count = 0;
  int lowc = 0;

  ebp_top dut (.clk_sys_i(clk), .resetn_i(rstn), .bank_size_i(bsz), .page_size_i(psz),
    .bus_master_i(mst), .bus_granted_away_i(away), .suspend_tristate_n_i(susp_n),
    .req_i(req), .req_write_i(req_wr), .req_cond_i(req_cond), .req_fmt_i(fmt),
    .req_addr_i(raddr), .req_wdata_i(wdat), .req_busy_o(busy), .done_o(done),
    .rdata_o(rdata), .slv_req_o(slv_req), .slv_write_o(slv_wr), .slv_addr_o(slv_addr),
    .slv_wdata_o(slv_wdat), .slv_wait_i(s_wait), .addr_i(s_addr), .addr_o(addr_o),
    .addr_oe_o(aoe), .data_i(mst ? data_m : s_data), .data_o(data_o), .data_oe_o(doe),
    .bank_select_n_o(bsel), .ctl_oe_o(coe), .rd_n_i(coe ? rd_n : s_rd_n), .rd_n_o(rd_n),
    .wr_n_i(coe ? wr_n : s_wr_n), .wr_n_o(wr_n),
    .early_store_select_n_i(coe ? esel_n : s_esel_n), .early_store_select_n_o(esel_n),
    .page_o(page), .bus_reference_clock_o(rclk), .ack_i(ack_oe ? ack_o : ack_m),
    .ack_o(ack_o), .ack_oe_o(ack_oe));

  ebp_mem_model mem (.clk_sys_i(clk), .addr_i(addr_o), .bsel_i(bsel), .page_i(page),
    .oe_i(aoe), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(data_o), .wait_i(m_wait),
    .ack_o(ack_m), .data_o(data_m), .cap_addr_o(c_addr), .cap_bsel_o(c_bsel),
    .cap_page_o(c_page), .cap_oe_o(c_oe), .cap_wdata_o(c_wdat));

  function automatic logic [39:0] ext(ebp_fmt_t f, logic [47:0] b);
    case (f)
      EBP_FMT_W32: return {8'h00, b[47:16]};
      EBP_FMT_W40: return b[47:8];
      EBP_FMT_W16: return {24'h00_0000, b[31:16]};
      default: return {32'h0000_0000, b[23:16]};
    endcase
  endfunction

  function automatic logic [39:0] msk(ebp_fmt_t f, logic [39:0] d);
    case (f)
      EBP_FMT_W32: return {8'h00, d[31:0]};
      EBP_FMT_W40: return d;
      EBP_FMT_W16: return {24'h00_0000, d[15:0]};
      default: return {32'h0000_0000, d[7:0]};
    endcase
  endfunction

  task automatic chk(string n, logic [47:0] s, logic [47:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic close_out;
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic mreq(logic w, logic c, ebp_fmt_t f, logic [31:0] a);
    ebp_exp_t x;
    int n;
    logic [31:0] b;
    logic es, ws;
    logic [3:0] sb;
    b = a >> bsz;
    x.slv = 0;
    x.wr = w;
    x.c = c;
    x.f = f;
    x.a = a;
    x.d = {8'($urandom), $urandom};
    x.bs = (b < 4) ? ~(4'h1 << b[1:0]) : 4'hf;
    if (c) begin
      x.pg = (b == 0) && (pg_new || ((a >> psz) != last_pg));
      if (b == 0) begin
        pg_new = 0;
        last_pg = a >> psz;
      end
    end
    // a false conditional still ends with done, so it takes a queue slot too
    exq.push_back(x);
    @(negedge clk);
    req = 1;
    req_wr = w;
    req_cond = c;
    fmt = f;
    raddr = a;
    wdat = x.d;
    m_wait = 4'($urandom_range(3, 0));
    n = 0;
    es = 0;
    ws = 0;
    sb = 4'hf;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    req = 0;
    while (busy === 1'b1 && n < 40) begin
      if (!esel_n) es = 1;
      if (!wr_n) ws = 1;
      if (bsel != 4'hf) sb = bsel;
      @(negedge clk);
      n++;
    end
    if (n >= 40) chk("busy", busy, 0);
    chk("early_sel", es, w);
    if (!c) begin
      chk("cond_wr", ws, 0);
      chk("cond_sel", sb, x.bs);
    end
  endtask

  task automatic sacc(logic w, logic [3:0] ws);
    ebp_exp_t x;
    int n;
    x.slv = 1;
    x.wr = w;
    x.a = $urandom;
    x.w = ws;
    x.d = {8'($urandom), $urandom};
    exq.push_back(x);
    @(negedge clk);
    s_addr = x.a;
    s_data = {x.d, 8'h00};
    s_wait = ws;
    s_esel_n = !w;
    if (w) s_wr_n = 0;
    else s_rd_n = 0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(ack_oe === 1'b1 && ack_o === 1'b1) && n < 30);
    @(negedge clk);
    s_rd_n = 1;
    s_wr_n = 1;
    s_esel_n = 1;
    while (ack_oe !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
  endtask

  // results leave the queue in the order the requests entered it
  always @(posedge clk) begin
    if (rstn && (done === 1'b1 || slv_req === 1'b1)) begin
      if (exq.size() == 0) begin
        chk("extra_result", 1'b1, 1'b0);
      end else begin
        e = exq.pop_front();
        if (e.slv) begin
          chk("slv_addr", slv_addr, e.a);
          chk("slv_write", slv_wr, e.wr);
          chk("ack_waits", lowc, e.w);
          if (e.wr) chk("slv_wdata", slv_wdat, e.d);
        end else if (e.c) begin
          chk("addr", c_addr, e.a);
          chk("bank_sel", c_bsel, e.bs);
          chk("page", c_page, e.pg);
          chk("addr_oe", c_oe, 1'b1);
          if (e.wr) chk("wdata", ext(e.f, c_wdat), msk(e.f, e.d));
          else chk("rdata", msk(e.f, rdata), ext(e.f, {~e.a[15:0], e.a}));
        end
      end
    end
    lowc = (!rstn || slv_req === 1'b1) ? 0 : lowc + int'(ack_oe === 1'b1 && ack_o === 1'b0);
  end

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // whole run needs well under this limit of 50000 cycles
  initial begin
    #5000000;
    failures++;
    close_out;
  end

  initial begin
    void'($urandom(40838));
    {rstn, away, req, req_wr} = 4'h0;
    {mst, susp_n, req_cond, s_rd_n, s_wr_n, s_esel_n, pg_new} = 7'h7f;
    bsz = 5'h10;
    psz = 5'h08;
    fmt = EBP_FMT_W32;
    {raddr, s_addr, last_pg} = '0;
    s_data = '0;
    wdat = '0;
    s_wait = 4'h0;
    m_wait = 4'h0;
    repeat (16) @(negedge clk);
    rstn = 1;
    repeat (3) @(negedge clk);
    rclk_d = rclk;
    @(negedge clk);
    chk("refclk_run", rclk, !rclk_d);
    mreq(0, 1, EBP_FMT_W32, 32'h0000_0010);
    mreq(1, 1, EBP_FMT_W40, 32'h0000_0020);
    for (int i = 0; i < 24; i++) begin
      mreq(i[2] && i[1:0] != 2'h3, 1, ebp_fmt_t'(i[1:0]),
           {16'($urandom_range(4, 0)), 16'($urandom)});
    end
    mreq(1, 0, EBP_FMT_W32, 32'h0001_0040);
    @(negedge clk);
    susp_n = 0;
    repeat (2) @(negedge clk);
    chk("susp_oe", {aoe, doe, coe}, 3'h0);
    susp_n = 1;
    away = 1;
    // the grant passes a two-flop synchroniser before it can refuse a request
    repeat (3) @(negedge clk);
    req = 1;
    repeat (5) @(negedge clk);
    chk("away_oe", {aoe, doe, coe}, 3'h0);
    chk("away_busy", busy, 1'b0);
    req = 0;
    away = 0;
    mst = 0;
    repeat (4) @(negedge clk);
    chk("refclk_idle", rclk, 1'b0);
    for (int w = 0; w < 4; w++) begin
      sacc(0, 4'(w));
      sacc(1, 4'(w));
    end
    repeat (4) @(negedge clk);
    chk("queue_left", exq.size(), 0);
    close_out;
  end
endmodule
